// ### hw/gain_stage_control.sv
// Gain-stage control word, reset handling, serialisation and power-down control
`timescale 1ns/1ps
module gain_stage_control
	import gain_stage_pkg::*;
#(
	parameter int WAKE_CYCLES = WAKE_CYC
) (
	input wire logic clock_i, // 10 MHz system clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire reg_access_s reg_i, // Register access from the serial engine
	input wire logic converter_reset_pin_n_i, // Converter reset pin, active low
	input wire logic converter_power_down_pin_i, // Converter sleep pin
	input wire logic gain_stage_power_down_pin_i, // Gain-stage sleep pin
	output logic [DATA_W-1:0] reg_rdata_o, // Read data of addressed register
	output logic gain_stage_select_o, // High while gain stage in reset
	output logic gain_stage_serial_clock_o, // Gated serial clock
	output logic gain_stage_serial_data_o, // Serial control word data
	output logic gain_stage_power_down_o, // Gain-stage power-down enable
	output logic filter_bw_narrow_o, // 1 = 12.5MHz, 0 = 17MHz
	output op_mode_e op_mode_o, // Decoded operating mode
	output amp_gain_e amp_gain_o, // Decoded amplifier gain
	output logic [CHANNELS-1:0][ROUTE_W-1:0] route_code_o, // Cross-point output per channel
	output logic [CHANNELS-1:0] route_to_rail_o, // Channel input tied to supply rail
	output logic [CHANNELS-1:0] channel_power_down_o, // Per-channel converter power-down
	output logic partial_sleep_o, // Partial power-down active
	output logic complete_sleep_o, // Complete power-down active
	output logic references_on_o, // Internal references powered
	output logic front_end_ready_o // Awake and wake time elapsed
);

	typedef enum logic [1:0] {ST_RESET, ST_IDLE, ST_START, ST_SHIFT} ctl_state_e;

	logic [2:0] pin_meta_r;
	logic [2:0] pin_sync_r;
	logic reset_pin_low;
	logic conv_pd_pin;
	logic gs_pd_pin;
	logic gs_reset_bit_r;
	logic select_now;
	logic [WORD_W-1:0] word_r;
	logic [WORD_W-1:0] word_nxt;
	logic word_write;
	logic word_change;
	logic pending_r;
	ctl_state_e state_r;
	logic shift_busy;
	logic [DATA_W-1:0] pd_r;
	logic complete_req;
	logic partial_req;
	logic [$clog2(WAKE_CYCLES+1)-1:0] run_cnt_r;
	logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt_r;
	ctrl_byte_s ctrl;

	// Merge a 16-bit write into the word; start and write flags stay one
	function automatic logic [WORD_W-1:0] merge_word(input logic [WORD_W-1:0] w,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [WORD_W-1:0] m;
		m = w;
		case (a)
			ADDR_WORD_LOW: m[DATA_W-1:0] = d;
			ADDR_WORD_MID: m[WORD_MID_LSB +: DATA_W] = d;
			ADDR_WORD_HIGH: m[WORD_HIGH_LSB +: WORD_HIGH_W] = d[WORD_HIGH_W-1:0];
			default: m = w;
		endcase
		m[1:0] = WORD_FORCED_ONES;
		return m;
	endfunction

	// Codes above the last cross-point output go to the supply rail
	function automatic logic is_rail(input logic [ROUTE_W-1:0] code);
		return code > ROUTE_MAX_OUTPUT;
	endfunction

	// Pins cross into the clock domain through two flops
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pin_meta_r <= 3'h1;
			pin_sync_r <= 3'h1;
		end else begin
			pin_meta_r <= {gain_stage_power_down_pin_i, converter_power_down_pin_i,
				converter_reset_pin_n_i};
			pin_sync_r <= pin_meta_r;
		end
	end

	// A 10ns pulse is shorter than one sample; one low sample counts
	assign reset_pin_low = !pin_sync_r[0];
	assign conv_pd_pin = pin_sync_r[1];
	assign gs_pd_pin = pin_sync_r[2];
	assign select_now = reset_pin_low || gs_reset_bit_r;
	assign ctrl = ctrl_byte_s'(word_r[CTRL_W-1:0]);

	// Reset bit stays set until software clears it
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			gs_reset_bit_r <= 1'b0;
		end else if (reg_i.wr && reg_i.addr == ADDR_RESET_CTRL) begin
			gs_reset_bit_r <= reg_i.data[GS_RESET_BIT_POS];
		end
	end

	// Select follows the reset sources
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			gain_stage_select_o <= 1'b1;
		end else begin
			gain_stage_select_o <= select_now;
		end
	end

	// Word writes are ignored while the gain stage is held in reset
	assign word_write = reg_i.wr && !select_now && (reg_i.addr == ADDR_WORD_LOW ||
		reg_i.addr == ADDR_WORD_MID || reg_i.addr == ADDR_WORD_HIGH);
	assign word_nxt = merge_word(word_r, reg_i.addr, reg_i.data);
	assign word_change = word_write && (word_nxt != word_r);

	// Control word storage
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || select_now) begin
			word_r <= WORD_RESET;
		end else if (word_change) begin
			word_r <= word_nxt;
		end
	end

	// A change during a transfer is kept and sent once it ends; set wins
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || select_now) begin
			pending_r <= 1'b0;
		end else if (word_change) begin
			pending_r <= 1'b1;
		end else if (state_r == ST_START) begin
			pending_r <= 1'b0; // Shifter loads the latest word here, so no repeat send
		end
	end

	// Transfer sequencing
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || select_now) begin
			state_r <= ST_RESET;
		end else begin
			case (state_r)
				ST_RESET: state_r <= ST_IDLE;
				ST_IDLE: state_r <= pending_r ? ST_START : ST_IDLE;
				ST_START: state_r <= ST_SHIFT;
				ST_SHIFT: state_r <= shift_busy ? ST_SHIFT : ST_IDLE;
				default: state_r <= ST_RESET;
			endcase
		end
	end

	// Whole word, D0 first; reset aborts and idles the lines
	gain_stage_shifter #(
		.WIDTH(WORD_W),
		.HALF_CYC(SCLK_HALF_CYC)
	) u_shifter (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.abort_i(select_now),
		.start_i(state_r == ST_START),
		.word_i(word_r),
		.sclk_o(gain_stage_serial_clock_o),
		.sdata_o(gain_stage_serial_data_o),
		.busy_o(shift_busy)
	);

	// Registered decode of the control byte and route fields
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			gain_stage_power_down_o <= 1'b0;
			filter_bw_narrow_o <= 1'b0;
			op_mode_o <= MODE_CONTINUOUS_WAVE;
			amp_gain_o <= GAIN_20DB;
		end else begin
			gain_stage_power_down_o <= ctrl.power_down_enable_bit;
			filter_bw_narrow_o <= ctrl.filter_bandwidth_select;
			op_mode_o <= op_mode_e'({ctrl.operating_mode_high_bit,
				ctrl.operating_mode_low_bit});
			amp_gain_o <= amp_gain_e'({ctrl.amp_gain_high_bit, ctrl.amp_gain_low_bit});
		end
	end

	// One route field per channel after the control byte
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_route
		always_ff @(posedge clock_i) begin
			if (!rst_n_i) begin
				route_code_o[ch] <= '0;
				route_to_rail_o[ch] <= 1'b0;
			end else begin
				route_code_o[ch] <= word_r[CTRL_W + ch*ROUTE_W +: ROUTE_W];
				route_to_rail_o[ch] <= is_rail(word_r[CTRL_W + ch*ROUTE_W +: ROUTE_W]);
			end
		end
	end

	// Power-down register
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pd_r <= PD_RESET;
		end else if (reg_i.wr && reg_i.addr == ADDR_POWER_DOWN) begin
			pd_r <= {{(DATA_W-PD_USED_W){1'b0}}, reg_i.data[PD_USED_W-1:0]};
		end
	end

	// Pin depth follows the config bit; gain-stage pin is always partial
	assign complete_req = (pd_r[PD_COMPLETE_POS] && ctrl.power_down_enable_bit) ||
		(conv_pd_pin && !pd_r[PD_PIN_CFG_POS]);
	assign partial_req = pd_r[PD_PARTIAL_POS] || (conv_pd_pin && pd_r[PD_PIN_CFG_POS]) ||
		gs_pd_pin;

	// Sleep takes effect one cycle after the request, well inside 1us
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			channel_power_down_o <= '0;
			complete_sleep_o <= 1'b0;
			partial_sleep_o <= 1'b0;
			references_on_o <= 1'b1;
		end else begin
			channel_power_down_o <= pd_r[CHANNELS-1:0];
			complete_sleep_o <= complete_req;
			partial_sleep_o <= partial_req && !complete_req;
			references_on_o <= !complete_req;
		end
	end

	// Wake needs the clock running and sleep released for the wake time
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			run_cnt_r <= '0;
			wake_cnt_r <= '0;
			front_end_ready_o <= 1'b0;
		end else begin
			if (run_cnt_r != $bits(run_cnt_r)'(WAKE_CYCLES)) begin
				run_cnt_r <= run_cnt_r + 1'b1;
			end
			if (complete_req || partial_req) begin
				wake_cnt_r <= '0;
			end else if (wake_cnt_r != $bits(wake_cnt_r)'(WAKE_CYCLES)) begin
				wake_cnt_r <= wake_cnt_r + 1'b1;
			end
			front_end_ready_o <= !complete_req && !partial_req &&
				wake_cnt_r == $bits(wake_cnt_r)'(WAKE_CYCLES) &&
				run_cnt_r == $bits(run_cnt_r)'(WAKE_CYCLES);
		end
	end

	// Read data registered; unmapped addresses read zero
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= '0;
		end else if (reg_i.rd) begin
			case (reg_i.addr)
				ADDR_RESET_CTRL: reg_rdata_o <= DATA_W'(gs_reset_bit_r) << GS_RESET_BIT_POS;
				ADDR_POWER_DOWN: reg_rdata_o <= pd_r;
				ADDR_WORD_LOW: reg_rdata_o <= word_r[DATA_W-1:0];
				ADDR_WORD_MID: reg_rdata_o <= word_r[WORD_MID_LSB +: DATA_W];
				ADDR_WORD_HIGH: reg_rdata_o <= {{(DATA_W-WORD_HIGH_W){1'b0}},
					word_r[WORD_HIGH_LSB +: WORD_HIGH_W]};
				default: reg_rdata_o <= '0;
			endcase
		end
	end

	chk_select_on_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		reset_pin_low |=> gain_stage_select_o)
		else $error("select not raised by reset pin");

	chk_reset_word: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		gs_reset_bit_r |=> word_r == WORD_RESET && gain_stage_select_o)
		else $error("word not at reset value during reset");

	chk_idle_lines: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		gain_stage_select_o |-> !gain_stage_serial_clock_o && !gain_stage_serial_data_o)
		else $error("serial lines active during reset");

	chk_reset_state_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		gs_reset_bit_r [*2] |-> state_r == ST_RESET)
		else $error("state left reset while reset bit set");

	chk_flags_fixed: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		word_r[1:0] == WORD_FORCED_ONES)
		else $error("start or write flag not one");

	chk_rail_route: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		route_to_rail_o[0] == (route_code_o[0] > ROUTE_MAX_OUTPUT))
		else $error("rail routing disagrees with code");

	chk_pin_depth: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		conv_pd_pin && !pd_r[PD_PIN_CFG_POS] |=> complete_sleep_o && !references_on_o)
		else $error("pin did not give complete sleep");

	chk_same_no_xfer: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		word_write && word_nxt == word_r && state_r == ST_IDLE && !pending_r
		|=> state_r == ST_IDLE && !pending_r)
		else $error("unchanged write started a transfer");

	chk_change_sends: assert property (@(posedge clock_i)
		disable iff (!rst_n_i || select_now)
		word_change && state_r == ST_IDLE && !pending_r |-> ##[4:6] gain_stage_serial_clock_o)
		else $error("changed word not sent");

	chk_first_bit: assert property (@(posedge clock_i)
		disable iff (!rst_n_i || select_now)
		state_r == ST_START |=> gain_stage_serial_data_o && !gain_stage_serial_clock_o)
		else $error("first bit is not the start flag");

endmodule

// ### hw/gain_stage_pkg.sv
// Constants, types and carriers shared by the gain-stage control word logic
package gain_stage_pkg;

	// Clock and timing
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESET_PULSE_NS = 10;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_HZ = 6_000_000;
	localparam int SCLK_HALF_CYC = CLK_HZ / (2 * OSC_HZ) < 1 ? 1 : CLK_HZ / (2 * OSC_HZ);
	localparam int SLEEP_ENTRY_NS = 1000;
	localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_NS / CLK_PERIOD_NS < 1 ? 1 :
		SLEEP_ENTRY_NS / CLK_PERIOD_NS;
	localparam int WAKE_US = 50;
	localparam int WAKE_CYC = (WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int WORD_W = 40;
	localparam int CHANNELS = 8;
	localparam int ROUTE_W = 4;

	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_RESET_CTRL = 8'h03;
	localparam logic [ADDR_W-1:0] ADDR_POWER_DOWN = 8'h0f;
	localparam logic [ADDR_W-1:0] ADDR_WORD_LOW = 8'h16;
	localparam logic [ADDR_W-1:0] ADDR_WORD_MID = 8'h17;
	localparam logic [ADDR_W-1:0] ADDR_WORD_HIGH = 8'h18;

	// Field positions
	localparam int GS_RESET_BIT_POS = 5;
	localparam int PD_PARTIAL_POS = 8;
	localparam int PD_COMPLETE_POS = 9;
	localparam int PD_PIN_CFG_POS = 10;
	localparam int PD_USED_W = 11;
	localparam int WORD_MID_LSB = 16;
	localparam int WORD_HIGH_LSB = 32;
	localparam int WORD_HIGH_W = 8;
	localparam int CTRL_W = 8;
	localparam logic [ROUTE_W-1:0] ROUTE_MAX_OUTPUT = 4'h9;

	// Reset values
	localparam logic [WORD_W-1:0] WORD_RESET = 40'h00_0000_0023;
	localparam logic [1:0] WORD_FORCED_ONES = 2'h3;
	localparam logic [DATA_W-1:0] PD_RESET = 16'h0000;

	// Decoded operating mode, in the order of its two-bit code
	typedef enum logic [1:0] {
		MODE_CONTINUOUS_WAVE,
		MODE_GAIN_RAMP_LOW_NOISE,
		MODE_GAIN_RAMP_LOW_POWER,
		MODE_PULSED_WAVE
	} op_mode_e;

	// Decoded amplifier gain: 20, 25, 27, 30 dB
	typedef enum logic [1:0] {
		GAIN_20DB,
		GAIN_25DB,
		GAIN_27DB,
		GAIN_30DB
	} amp_gain_e;

	// Control byte overlay, bit 7 first
	typedef struct packed {
		logic amp_gain_high_bit;
		logic amp_gain_low_bit;
		logic operating_mode_high_bit;
		logic operating_mode_low_bit;
		logic filter_bandwidth_select;
		logic power_down_enable_bit;
		logic write_flag;
		logic start_flag;
	} ctrl_byte_s;

	// Register access from the serial configuration engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} reg_access_s;

endpackage

// ### hw/gain_stage_shifter.sv
// Gated serial shifter for the 40-bit gain-stage control word
`timescale 1ns/1ps
module gain_stage_shifter
	import gain_stage_pkg::*;
#(
	parameter int WIDTH = WORD_W,
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	input wire logic clock_i, // System clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic abort_i, // Gain-stage reset, forces idle lines
	input wire logic start_i, // Load word and begin shifting
	input wire logic [WIDTH-1:0] word_i, // Word to send
	output logic sclk_o, // Gated serial clock
	output logic sdata_o, // Serial data, LSB first
	output logic busy_o // Transfer in progress
);

	logic [WIDTH-1:0] shift_r;
	logic [$clog2(WIDTH)-1:0] bit_cnt_r;
	logic [$clog2(HALF_CYC+1)-1:0] half_cnt_r;
	logic half_done;

	assign half_done = (half_cnt_r == $bits(half_cnt_r)'(HALF_CYC - 1));

	// Clock only toggles while busy; data moves on the falling edge
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || abort_i) begin
			shift_r <= '0;
			bit_cnt_r <= '0;
			half_cnt_r <= '0;
			sclk_o <= 1'b0;
			sdata_o <= 1'b0;
			busy_o <= 1'b0;
		end else if (start_i && !busy_o) begin
			shift_r <= word_i;
			bit_cnt_r <= '0;
			half_cnt_r <= '0;
			sclk_o <= 1'b0;
			sdata_o <= word_i[0];
			busy_o <= 1'b1;
		end else if (busy_o) begin
			half_cnt_r <= half_done ? '0 : half_cnt_r + 1'b1;
			if (half_done) begin
				if (!sclk_o) begin
					sclk_o <= 1'b1;
				end else begin
					sclk_o <= 1'b0;
					if (bit_cnt_r == $bits(bit_cnt_r)'(WIDTH - 1)) begin
						busy_o <= 1'b0;
						sdata_o <= 1'b0; // Data rests low between words
					end else begin
						bit_cnt_r <= bit_cnt_r + 1'b1;
						shift_r <= shift_r >> 1;
						sdata_o <= shift_r[1];
					end
				end
			end
		end
	end

endmodule

// ### tb/config_host.sv
// Host controller model driving the register port and the sleep and reset pins
`timescale 1ns/1ps
module config_host
	import gain_stage_pkg::*;
(
	input wire logic clock_i, // System clock
	input wire logic [DATA_W-1:0] rdata_i, // Read data from the block
	output reg_access_s reg_o, // Register access strobes
	output logic reset_pin_n_o, // Converter reset pin, active low
	output logic adc_pd_pin_o, // Converter sleep pin
	output logic gs_pd_pin_o // Gain-stage sleep pin
);
	// Sleep pins low for normal operation, bus idle
	initial begin
		reg_o = '0;
		reset_pin_n_o = 1'b1;
		adc_pd_pin_o = 1'b0;
		gs_pd_pin_o = 1'b0;
	end

	// One-cycle write strobe launched off the falling edge
	task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clock_i);
		reg_o.wr = 1'b1;
		reg_o.addr = a;
		reg_o.data = d;
		@(negedge clock_i);
		reg_o.wr = 1'b0;
		reg_o.data = ~d; // Released data never keeps the last value
	endtask

	// Read strobe, data taken once the registered answer has landed
	task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(negedge clock_i);
		reg_o.rd = 1'b1;
		reg_o.addr = a;
		@(negedge clock_i);
		reg_o.rd = 1'b0;
		@(negedge clock_i);
		d = rdata_i;
	endtask

	// Pin levels change only off the falling edge
	task automatic set_pins(input logic rst_n, input logic adc_pd, input logic gs_pd);
		@(negedge clock_i);
		reset_pin_n_o = rst_n;
		adc_pd_pin_o = adc_pd;
		gs_pd_pin_o = gs_pd;
	endtask
endmodule

// ### tb/tb_gain_stage_control.sv
// Self-checking bench for the gain-stage control word block
`timescale 1ns/1ps
module tb_gain_stage_control
	import gain_stage_pkg::*;
;
	logic clock, rst_n, rst_pin_n, adc_pd, gs_pd, sel, sclk, sdata, gs_pd_o, bw, partial, complete;
	logic refs, ready;
	reg_access_s reg_a;
	logic [DATA_W-1:0] rdata;
	op_mode_e mode;
	amp_gain_e gain;
	logic [CHANNELS-1:0][ROUTE_W-1:0] route;
	logic [CHANNELS-1:0] rail, ch_pd;
	logic [WORD_W-1:0] cap_r;
	int cap_n, mismatches, checks_done;
	logic [3:0] codes [8] = '{4'h0, 4'h9, 4'ha, 4'hf, 4'h1, 4'h8, 4'hb, 4'h5};

	config_host config_host_i (.clock_i(clock), .rdata_i(rdata), .reg_o(reg_a),
		.reset_pin_n_o(rst_pin_n), .adc_pd_pin_o(adc_pd), .gs_pd_pin_o(gs_pd));

	// Small wake count keeps the run short
	gain_stage_control #(.WAKE_CYCLES(4)) gain_stage_control_i (.clock_i(clock), .rst_n_i(rst_n),
		.reg_i(reg_a), .converter_reset_pin_n_i(rst_pin_n), .converter_power_down_pin_i(adc_pd),
		.gain_stage_power_down_pin_i(gs_pd), .reg_rdata_o(rdata), .gain_stage_select_o(sel),
		.gain_stage_serial_clock_o(sclk), .gain_stage_serial_data_o(sdata),
		.gain_stage_power_down_o(gs_pd_o), .filter_bw_narrow_o(bw), .op_mode_o(mode),
		.amp_gain_o(gain), .route_code_o(route), .route_to_rail_o(rail),
		.channel_power_down_o(ch_pd), .partial_sleep_o(partial), .complete_sleep_o(complete),
		.references_on_o(refs), .front_end_ready_o(ready));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Serial capture, first bit ends up at the bottom
	always @(posedge sclk) begin
		cap_r = {sdata, cap_r[WORD_W-1:1]};
		cap_n++;
	end

	task automatic give_verdict();
		if (mismatches == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp,
		input string what);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	// Bounded wait on a flag; running out ends the run
	task automatic wait_high(ref logic f, input int lim, input string what);
		int n;
		n = 0;
		while (f !== 1'b1 && n < lim) begin
			@(negedge clock);
			n++;
		end
		if (f !== 1'b1) begin
			check(f, 1, what);
			give_verdict();
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		cap_n = 0;
		config_host_i.write_reg(a, d);
	endtask

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] d;
		config_host_i.read_reg(a, d);
		check(d, exp, "read data");
	endtask

	// Whole word sent once, low bit first, clock parked afterwards
	task automatic wait_xfer(input logic [WORD_W-1:0] exp);
		int n;
		n = 0;
		while (cap_n < WORD_W && n < 200) begin
			@(negedge clock);
			n++;
		end
		cyc(4);
		check(cap_n, WORD_W, "bit count");
		check(cap_r, exp, "serial word");
		check(sclk, 0, "clock idle");
		if (n == 200) begin
			give_verdict();
		end
	endtask

	task automatic t_reset_values();
		check(sel, 0, "select after reset");
		rd_chk(ADDR_WORD_LOW, 16'h0023);
		rd_chk(ADDR_WORD_MID, 16'h0000);
		rd_chk(ADDR_WORD_HIGH, 16'h0000);
		rd_chk(ADDR_POWER_DOWN, 16'h0000);
		rd_chk(8'h20, 16'h0000);
		check(mode, MODE_GAIN_RAMP_LOW_POWER, "mode after reset");
		check(gain, GAIN_20DB, "gain after reset");
		check(bw, 0, "bandwidth after reset");
	endtask

	task automatic t_serial_routes();
		wr(ADDR_WORD_MID, 16'h81fa);
		wait_xfer({8'h00, 16'h81fa, 16'h0023});
		wr(ADDR_WORD_HIGH, 16'hff5b);
		wait_xfer({8'h5b, 16'h81fa, 16'h0023});
		wr(ADDR_WORD_LOW, 16'h90fc);
		wait_xfer({8'h5b, 16'h81fa, 16'h90ff});
		wr(ADDR_WORD_LOW, 16'h90fc);
		cyc(100);
		check(cap_n, 0, "unchanged write sent");
		rd_chk(ADDR_WORD_HIGH, 16'h005b);
		rd_chk(ADDR_WORD_LOW, 16'h90ff);
		for (int i = 0; i < CHANNELS; i++) begin
			check(route[i], codes[i], "route code");
			check(rail[i], codes[i] > 4'h9, "rail tie");
		end
	endtask

	// Every mode and gain code, with bandwidth and power-down toggling
	task automatic t_decode();
		logic [1:0] g;
		logic [DATA_W-1:0] d;
		for (int i = 0; i < 4; i++) begin
			g = i[1:0];
			d = {8'h90, g, ~g, g[0], ~g[0], 2'b00};
			wr(ADDR_WORD_LOW, d);
			wait_xfer({8'h5b, 16'h81fa, d | 16'h0003});
			check(gain, g, "gain decode");
			check(mode, 2'(~g), "mode decode");
			check(bw, g[0], "bandwidth decode");
			check(gs_pd_o, 1'(~g[0]), "power-down bit");
		end
	endtask

	task automatic t_reset_bit();
		wr(ADDR_RESET_CTRL, 16'h0020);
		cyc(2);
		check(sel, 1, "select by bit");
		rd_chk(ADDR_WORD_MID, 16'h0000);
		rd_chk(ADDR_RESET_CTRL, 16'h0020);
		wr(ADDR_WORD_LOW, 16'h1234);
		cyc(100);
		check(cap_n, 0, "lines quiet in reset");
		check(sel, 1, "select held");
		rd_chk(ADDR_WORD_LOW, 16'h0023);
		wr(ADDR_RESET_CTRL, 16'h0000);
		cyc(20);
		check(sel, 0, "select released");
		check(cap_n, 0, "no send on release");
		wr(ADDR_WORD_MID, 16'h0001);
		wait_xfer({8'h00, 16'h0001, 16'h0023});
		config_host_i.set_pins(1'b0, 1'b0, 1'b0);
		cyc(1);
		config_host_i.set_pins(1'b1, 1'b0, 1'b0);
		wait_high(sel, 10, "select by pin");
		cyc(5);
		rd_chk(ADDR_WORD_MID, 16'h0000);
	endtask

	task automatic t_power();
		wr(ADDR_POWER_DOWN, 16'h00a5);
		cyc(2);
		check(ch_pd, 8'ha5, "channel power-down");
		wr(ADDR_POWER_DOWN, 16'h0100);
		cyc(2);
		check({partial, complete, refs}, 3'b101, "partial by bit");
		wr(ADDR_POWER_DOWN, 16'h0000);
		wait_high(ready, 30, "wake up");
		wr(ADDR_WORD_LOW, 16'h0004);
		wait_xfer({8'h00, 16'h0000, 16'h0007});
		wr(ADDR_POWER_DOWN, 16'h0200);
		cyc(2);
		check({partial, complete, refs}, 3'b010, "complete by bit");
		wr(ADDR_POWER_DOWN, 16'h0000);
		config_host_i.set_pins(1'b1, 1'b1, 1'b0);
		cyc(5);
		check({partial, complete}, 2'b01, "pin complete");
		wr(ADDR_POWER_DOWN, 16'h0400);
		cyc(2);
		check({partial, complete}, 2'b10, "pin partial");
		config_host_i.set_pins(1'b1, 1'b0, 1'b1);
		cyc(5);
		check({partial, complete}, 2'b10, "gain-stage pin");
		config_host_i.set_pins(1'b1, 1'b0, 1'b0);
		rd_chk(ADDR_POWER_DOWN, 16'h0400);
	endtask

	initial begin
		mismatches = 0;
		checks_done = 0;
		cap_n = 0;
		cap_r = '0;
		rst_n = 1'b0;
		cyc(5);
		rst_n = 1'b1;
		cyc(1);
		t_reset_values();
		t_serial_routes();
		t_decode();
		t_reset_bit();
		t_power();
		give_verdict();
	end
endmodule
